// ### common/hsc_cfg.svh
// Register offsets, field positions and reset values of the serial port
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH

// Register byte offsets
`define HSC_OFS_CTRL 8'h00
`define HSC_OFS_STAT 8'h04

// Control register bit positions
`define HSC_CTRL_CA_EN 0
`define HSC_CTRL_LOOPBACK 1
`define HSC_CTRL_TX_INV 2
`define HSC_CTRL_RX_INV 3
`define HSC_CTRL_CD_LOW 4
`define HSC_CTRL_GATED 5
`define HSC_CTRL_CARRIER 6

// Control reset: DCE-available allowed, carrier enabled, all else off
`define HSC_CTRL_RESET 32'h0000_0041
`define HSC_CTRL_RESET_BIT(b) 1'(`HSC_CTRL_RESET >> (b))

// Status register bit positions
`define HSC_STAT_TA 0
`define HSC_STAT_LA 1
`define HSC_STAT_LB 2
`define HSC_STAT_DTE_UP 3
`define HSC_STAT_CA 4
`define HSC_STAT_INIT 5
`define HSC_STAT_LOCK 6

// Delay from a link pin change to the sampled copy, in pclk cycles
`define HSC_SYNC_CYCLES 2

`endif

// ### common/hsc_pkg.sv
// Types shared by the serial port modules
package hsc_pkg;

  typedef enum logic [2:0] {
    HSC_INIT  = 3'b001,
    HSC_AVAIL = 3'b010,
    HSC_DOWN  = 3'b100
  } hsc_ca_e;

  typedef struct packed {
    logic ca_en;
    logic loopback;
    logic tx_inv;
    logic rx_inv;
    logic cd_low;
    logic gated;
    logic carrier;
  } hsc_ctrl_s;

  typedef struct packed {
    logic ta;
    logic la;
    logic lb;
  } hsc_hs_in_s;

  typedef struct packed {
    logic ca;
    logic lc;
    logic tm;
  } hsc_hs_out_s;

endpackage

// ### rtl/hsc_port.sv
// High-speed serial DCE port: APB registers, handshake, fault pins
//
// How it works
// - Synchronous data from 1.5 to 70 Mbps.
// - Interface clocks nominally 50% duty cycle.
// - Lines change on rising, stable at falling.
// - Normal TX phase samples on TT falling.
// - Inverted TX phase samples on TT rising.
// - Normal RX phase centres RT falling edge.
// - Inverted RX phase centres RT rising edge.
// - Status register shows TA, LA, LB levels.
// - CA gated, TM driven from control register.
// - TA low reports terminal unavailable.
// - Gated carrier follows TA when enabled.
// - CA unavailable until init done, fault-free.
// - CA available once init completes cleanly.
// - Non-operational fault drops CA to unavailable.
// - TM active only when loopback commanded.
// - LC always held inactive.
// - LA and LB readable, otherwise ignored.
// - Carrier-lock output with programmable polarity.
// - Demod fault open-collector, active high.
// - Mod fault open-collector, active high.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "hsc_cfg.svh"
module hsc_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modem status
  input wire logic init_done,
  input wire logic modem_fault,
  input wire logic mod_fault,
  input wire logic demod_fault,
  input wire logic carrier_locked,
  output logic rf_carrier_on,
  // Transmit data to modulator
  output logic tx_bit,
  output logic tx_valid,
  // Receive data from demodulator
  input wire logic rx_bit,
  output logic rx_take,
  // Link data and timing
  input wire logic tt,
  input wire logic sd,
  input wire logic rt,
  output logic rd,
  // Link handshake
  input wire hsc_pkg::hsc_hs_in_s hs_in,
  output hsc_pkg::hsc_hs_out_s hs_out,
  // Fault and lock pins
  output logic carrier_lock_out,
  output logic demod_fault_out,
  output logic demod_fault_oe,
  output logic mod_fault_out,
  output logic mod_fault_oe
);
  import hsc_pkg::*;

  hsc_ctrl_s ctrl, next_ctrl;
  hsc_ca_e ca_state, next_ca_state;
  hsc_hs_in_s hs_s1, hs_s2;
  hsc_hs_out_s next_hs_out;
  logic [31:0] next_prdata, ctrl_word, stat_word;
  logic next_pready, next_pslverr, hit_ctrl, hit_stat, wr_ctrl;
  logic next_rf, next_cd, next_df_oe, next_mf_oe, oc_level, fault;

  // Data paths on the link timing clocks
  hsc_tx_sampler u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .tx_inv(ctrl.tx_inv),
    .tt(tt),
    .sd(sd),
    .tx_bit(tx_bit),
    .tx_valid(tx_valid)
  );

  hsc_rx_launcher u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .rx_inv(ctrl.rx_inv),
    .rx_bit(rx_bit),
    .rx_take(rx_take),
    .rt(rt),
    .rd(rd)
  );

  // Register views
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`HSC_CTRL_CA_EN] = ctrl.ca_en;
    ctrl_word[`HSC_CTRL_LOOPBACK] = ctrl.loopback;
    ctrl_word[`HSC_CTRL_TX_INV] = ctrl.tx_inv;
    ctrl_word[`HSC_CTRL_RX_INV] = ctrl.rx_inv;
    ctrl_word[`HSC_CTRL_CD_LOW] = ctrl.cd_low;
    ctrl_word[`HSC_CTRL_GATED] = ctrl.gated;
    ctrl_word[`HSC_CTRL_CARRIER] = ctrl.carrier;
    stat_word = 32'h0000_0000;
    stat_word[`HSC_STAT_TA] = hs_s2.ta;
    stat_word[`HSC_STAT_LA] = hs_s2.la;
    stat_word[`HSC_STAT_LB] = hs_s2.lb;
    stat_word[`HSC_STAT_DTE_UP] = hs_s2.ta;
    stat_word[`HSC_STAT_CA] = hs_out.ca;
    stat_word[`HSC_STAT_INIT] = init_done;
    stat_word[`HSC_STAT_LOCK] = carrier_locked;
  end

  // APB slave: one wait-free access phase after each setup
  always_comb begin
    hit_ctrl = (paddr == `HSC_OFS_CTRL);
    hit_stat = (paddr == `HSC_OFS_STAT);
    next_pready = psel & ~penable;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_pslverr = ~(hit_ctrl | hit_stat);
      if (pwrite) begin
        next_prdata = 32'h0000_0000;
      end else if (hit_ctrl) begin
        next_prdata = ctrl_word;
      end else if (hit_stat) begin
        next_prdata = stat_word;
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
    wr_ctrl = psel & penable & pready & pwrite & hit_ctrl;
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.ca_en = pwdata[`HSC_CTRL_CA_EN];
      next_ctrl.loopback = pwdata[`HSC_CTRL_LOOPBACK];
      next_ctrl.tx_inv = pwdata[`HSC_CTRL_TX_INV];
      next_ctrl.rx_inv = pwdata[`HSC_CTRL_RX_INV];
      next_ctrl.cd_low = pwdata[`HSC_CTRL_CD_LOW];
      next_ctrl.gated = pwdata[`HSC_CTRL_GATED];
      next_ctrl.carrier = pwdata[`HSC_CTRL_CARRIER];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl.ca_en <= `HSC_CTRL_RESET_BIT(`HSC_CTRL_CA_EN);
      ctrl.loopback <= `HSC_CTRL_RESET_BIT(`HSC_CTRL_LOOPBACK);
      ctrl.tx_inv <= `HSC_CTRL_RESET_BIT(`HSC_CTRL_TX_INV);
      ctrl.rx_inv <= `HSC_CTRL_RESET_BIT(`HSC_CTRL_RX_INV);
      ctrl.cd_low <= `HSC_CTRL_RESET_BIT(`HSC_CTRL_CD_LOW);
      ctrl.gated <= `HSC_CTRL_RESET_BIT(`HSC_CTRL_GATED);
      ctrl.carrier <= `HSC_CTRL_RESET_BIT(`HSC_CTRL_CARRIER);
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      ctrl <= next_ctrl;
    end
  end

  // DCE-available sequencing
  always_comb begin
    fault = modem_fault;
    next_ca_state = ca_state;
    unique case (ca_state)
      HSC_INIT: begin
        if (init_done && !fault) begin
          next_ca_state = HSC_AVAIL;
        end
      end
      HSC_AVAIL: begin
        if (fault) begin
          next_ca_state = HSC_DOWN;
        end
      end
      HSC_DOWN: begin
        if (init_done && !fault) begin
          next_ca_state = HSC_AVAIL;
        end
      end
    endcase
  end

  // Handshake and fault pins
  always_comb begin
    next_hs_out.ca = (ca_state == HSC_AVAIL) & ctrl.ca_en;
    next_hs_out.lc = 1'b0;
    next_hs_out.tm = ctrl.loopback;
    next_rf = ctrl.carrier & (~ctrl.gated | hs_s2.ta);
    next_cd = carrier_locked ^ ctrl.cd_low;
    next_df_oe = ~demod_fault;
    next_mf_oe = ~mod_fault;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ca_state <= HSC_INIT;
      hs_s1 <= '0;
      hs_s2 <= '0;
      hs_out <= '0;
      rf_carrier_on <= 1'b0;
      carrier_lock_out <= 1'b0;
      demod_fault_oe <= 1'b1;
      mod_fault_oe <= 1'b1;
      oc_level <= 1'b0;
    end else begin
      ca_state <= next_ca_state;
      hs_s1 <= hs_in;
      hs_s2 <= hs_s1;
      hs_out <= next_hs_out;
      rf_carrier_on <= next_rf;
      carrier_lock_out <= next_cd;
      demod_fault_oe <= next_df_oe;
      mod_fault_oe <= next_mf_oe;
      oc_level <= 1'b0;
    end
  end

  // Open-collector pins only ever pull low
  assign demod_fault_out = oc_level;
  assign mod_fault_out = oc_level;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ca_needs_init;
    !init_done |-> ##1 !hs_out.ca;
  endproperty
  a_ca_needs_init: assert property (p_ca_needs_init)
    else $error("CA available before init done");

  property p_ca_up;
    (init_done && !modem_fault && ctrl.ca_en)[*3] |-> hs_out.ca;
  endproperty
  a_ca_up: assert property (p_ca_up)
    else $error("CA not available after clean init");

  property p_ca_fault;
    modem_fault |-> ##2 !hs_out.ca;
  endproperty
  a_ca_fault: assert property (p_ca_fault)
    else $error("CA stays available under fault");

  property p_tm;
    ##1 hs_out.tm == $past(ctrl.loopback);
  endproperty
  a_tm: assert property (p_tm)
    else $error("TM does not follow loopback command");

  property p_lc;
    !hs_out.lc;
  endproperty
  a_lc: assert property (p_lc)
    else $error("LC driven active");

  property p_cd;
    ##1 carrier_lock_out == ($past(carrier_locked) ^ $past(ctrl.cd_low));
  endproperty
  a_cd: assert property (p_cd)
    else $error("carrier lock pin wrong");

  property p_df;
    demod_fault |=> !demod_fault_oe && !demod_fault_out;
  endproperty
  a_df: assert property (p_df)
    else $error("demod fault pin not released");

  property p_mf;
    !mod_fault |=> mod_fault_oe && !mod_fault_out;
  endproperty
  a_mf: assert property (p_mf)
    else $error("mod fault pin not pulled low");

  property p_gate;
    (ctrl.gated && ctrl.carrier && !hs_s2.ta) |=> !rf_carrier_on;
  endproperty
  a_gate: assert property (p_gate)
    else $error("carrier on while terminal down");

  property p_stat_rd;
    (psel && !penable && !pwrite && hit_stat) |=>
      prdata[`HSC_STAT_TA] == $past(hs_s2.ta) && pready;
  endproperty
  a_stat_rd: assert property (p_stat_rd)
    else $error("status read does not show TA");

  property p_cv_avail;
    ca_state == HSC_INIT ##1 ca_state == HSC_AVAIL;
  endproperty
  c_cv_avail: cover property (p_cv_avail);

  property p_cv_down;
    ca_state == HSC_AVAIL ##1 ca_state == HSC_DOWN;
  endproperty
  c_cv_down: cover property (p_cv_down);

  property p_cv_write;
    wr_ctrl && pwdata[`HSC_CTRL_TX_INV];
  endproperty
  c_cv_write: cover property (p_cv_write);

endmodule // hsc_port

// ### rtl/hsc_rx_launcher.sv
// Receive data launcher on the receive timing clock
`timescale 1ns/1ps
module hsc_rx_launcher (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Phase select
  input wire logic rx_inv,
  // User side
  input wire logic rx_bit,
  output logic rx_take,
  // Link pins
  input wire logic rt,
  output logic rd
);

  logic rt_s1, rt_s2, rt_s3;
  logic next_rd, next_take, launch;

  // Launch on the edge opposite the one centred in the bit
  always_comb begin
    launch = rx_inv ? (rt_s3 & ~rt_s2) : (~rt_s3 & rt_s2);
    next_take = launch;
    next_rd = launch ? rx_bit : rd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_s1 <= 1'b0;
      rt_s2 <= 1'b0;
      rt_s3 <= 1'b0;
      rd <= 1'b0;
      rx_take <= 1'b0;
    end else begin
      rt_s1 <= rt;
      rt_s2 <= rt_s1;
      rt_s3 <= rt_s2;
      rd <= next_rd;
      rx_take <= next_take;
    end
  end

  property p_rd_launch;
    @(posedge pclk) disable iff (!presetn)
      (rt_s2 != rt_s3 && rt_s2 == !rx_inv) |=> rd == $past(rx_bit);
  endproperty
  a_rd_launch: assert property (p_rd_launch)
    else $error("receive data not launched on opposite edge");

  property p_rd_hold;
    @(posedge pclk) disable iff (!presetn)
      (rt_s2 != rt_s3 && rt_s2 == rx_inv) |=> $stable(rd);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("receive data moved on centred edge");

endmodule // hsc_rx_launcher

// ### rtl/hsc_tx_sampler.sv
// Send data sampler on the terminal timing clock
`timescale 1ns/1ps
module hsc_tx_sampler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Phase select
  input wire logic tx_inv,
  // Link pins
  input wire logic tt,
  input wire logic sd,
  // Sampled data
  output logic tx_bit,
  output logic tx_valid
);

  logic tt_s1, tt_s2, tt_s3, sd_s1, sd_s2;
  logic next_bit, next_valid, fall, rise, take;

  always_comb begin
    fall = tt_s3 & ~tt_s2;
    rise = ~tt_s3 & tt_s2;
    take = tx_inv ? rise : fall;
    next_valid = take;
    next_bit = take ? sd_s2 : tx_bit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tt_s1 <= 1'b0;
      tt_s2 <= 1'b0;
      tt_s3 <= 1'b0;
      sd_s1 <= 1'b0;
      sd_s2 <= 1'b0;
      tx_bit <= 1'b0;
      tx_valid <= 1'b0;
    end else begin
      tt_s1 <= tt;
      tt_s2 <= tt_s1;
      tt_s3 <= tt_s2;
      sd_s1 <= sd;
      sd_s2 <= sd_s1;
      tx_bit <= next_bit;
      tx_valid <= next_valid;
    end
  end

  property p_fall_sample;
    @(posedge pclk) disable iff (!presetn)
      (fall && !tx_inv) |=> (tx_valid && tx_bit == $past(sd_s2));
  endproperty
  a_fall_sample: assert property (p_fall_sample)
    else $error("send data not taken on falling edge");

  property p_rise_sample;
    @(posedge pclk) disable iff (!presetn)
      (rise && tx_inv) |=> (tx_valid && tx_bit == $past(sd_s2));
  endproperty
  a_rise_sample: assert property (p_rise_sample)
    else $error("send data not taken on rising edge");

endmodule // hsc_tx_sampler

// ### verification/hsc_dte_model.sv
// Terminal-side link model: send data and timing, receive data capture
`timescale 1ns/1ps
module hsc_dte_model (
  // Timing and data towards the port
  output logic tt,
  output logic sd,
  output logic rt,
  // Receive data from the port
  input wire logic rd
);
  initial begin
    tt = 1'b0;
    sd = 1'b0;
    rt = 1'b0;
  end
  // Clocks stand low between frames
  task automatic send(input logic [7:0] pat, input logic inv);
    #7;
    for (int i = 0; i < 8; i++) begin
      if (inv) begin
        sd = pat[i];
        #80 tt = 1'b1;
        #160 tt = 1'b0;
        #80;
      end else begin
        tt = 1'b1;
        sd = pat[i];
        #160 tt = 1'b0;
        #160;
      end
    end
    // Stale data must not look valid
    sd = ~sd;
  endtask
  task automatic recv(input logic inv, output logic [7:0] got);
    #7;
    for (int i = 0; i < (inv ? 9 : 8); i++) begin
      rt = 1'b1;
      if (inv && i > 0) got[i-1] = rd;
      #160 rt = 1'b0;
      if (!inv) got[i] = rd;
      #160;
    end
  endtask
endmodule // hsc_dte_model

// ### verification/test_hsc_port.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`include "hsc_cfg.svh"
module test_hsc_port;
  import hsc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
  logic [7:0] paddr, tx_q, rx_pat, got;
  logic [31:0] pwdata, prdata, rd_v;
  logic init_done, modem_fault, mod_fault, demod_fault, carrier_locked;
  logic rf_carrier_on, tx_bit, tx_valid, rx_bit, rx_take;
  logic tt, sd, rt, rd, carrier_lock_out;
  logic demod_fault_out, demod_fault_oe, mod_fault_out, mod_fault_oe;
  logic [2:0] ridx;
  hsc_hs_in_s hs_in;
  hsc_hs_out_s hs_out;
  int tx_n, error_cnt, compares;
  // Open-collector pins with pull-ups
  wire demod_pin = demod_fault_oe ? demod_fault_out : 1'b1;
  wire mod_pin = mod_fault_oe ? mod_fault_out : 1'b1;

  hsc_port uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .init_done, .modem_fault,
    .mod_fault, .demod_fault, .carrier_locked, .rf_carrier_on, .tx_bit,
    .tx_valid, .rx_bit, .rx_take, .tt, .sd, .rt, .rd, .hs_in, .hs_out,
    .carrier_lock_out, .demod_fault_out, .demod_fault_oe, .mod_fault_out,
    .mod_fault_oe);
  hsc_dte_model dte (.tt, .sd, .rt, .rd);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (tx_valid === 1'b1) begin
      tx_q[tx_n[2:0]] <= tx_bit;
      tx_n <= tx_n + 1;
    end
    if (rx_take === 1'b1) begin
      ridx <= ridx + 3'd1;
      rx_bit <= rx_pat[ridx+3'd1];
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_avail();
    apb(0, `HSC_OFS_CTRL, 0);
    chk(rd_v, `HSC_CTRL_RESET);
    chk(hs_out, 3'b000);
    init_done <= 1'b1;
    wt(4);
    chk(hs_out.ca, 1);
    modem_fault <= 1'b1;
    wt(4);
    chk(hs_out.ca, 0);
    modem_fault <= 1'b0;
    wt(4);
    chk(hs_out.ca, 1);
  endtask

  task automatic t_tm();
    apb(1, `HSC_OFS_CTRL, 32'h43);
    wt(3);
    chk(hs_out, 3'b101);
    apb(1, `HSC_OFS_CTRL, 32'h41);
    wt(3);
    chk(hs_out, 3'b100);
  endtask

  task automatic t_stat();
    for (int v = 0; v < 8; v++) begin
      hs_in <= v[2:0];
      wt(4);
      apb(0, `HSC_OFS_STAT, 0);
      chk(rd_v[3:0], {v[2], v[0], v[1], v[2]});
    end
    apb(0, 8'h08, 0);
    chk(err_v, 1);
    chk(rd_v, 0);
  endtask

  task automatic t_gate();
    apb(1, `HSC_OFS_CTRL, 32'h61);
    hs_in <= 3'b000;
    wt(5);
    chk(rf_carrier_on, 0);
    hs_in <= 3'b100;
    wt(5);
    chk(rf_carrier_on, 1);
    apb(1, `HSC_OFS_CTRL, 32'h41);
    hs_in <= 3'b000;
    wt(5);
    chk(rf_carrier_on, 1);
  endtask

  task automatic t_pins();
    carrier_locked <= 1'b1;
    wt(3);
    chk(carrier_lock_out, 1);
    apb(1, `HSC_OFS_CTRL, 32'h51);
    carrier_locked <= 1'b0;
    wt(3);
    chk(carrier_lock_out, 1);
    apb(1, `HSC_OFS_CTRL, 32'h41);
    demod_fault <= 1'b1;
    wt(3);
    chk({demod_pin, mod_pin}, 2'b10);
    demod_fault <= 1'b0;
    mod_fault <= 1'b1;
    wt(3);
    chk({demod_pin, mod_pin}, 2'b01);
    mod_fault <= 1'b0;
  endtask

  task automatic t_tx(input logic inv, input logic [7:0] pat);
    apb(1, `HSC_OFS_CTRL, inv ? 32'h45 : 32'h41);
    apb(0, `HSC_OFS_CTRL, 0);
    chk(rd_v, inv ? 32'h45 : 32'h41);
    tx_n <= 0;
    dte.send(pat, inv);
    wt(10);
    chk(tx_n, 8);
    chk(tx_q, pat);
  endtask

  task automatic t_rx(input logic inv, input logic [7:0] pat);
    apb(1, `HSC_OFS_CTRL, inv ? 32'h49 : 32'h41);
    ridx <= 3'd0;
    rx_pat <= pat;
    rx_bit <= pat[0];
    wt(2);
    dte.recv(inv, got);
    chk(got, pat);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100_000;
    error_cnt++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {init_done, modem_fault, mod_fault, demod_fault} = '0;
    {carrier_locked, rx_bit, hs_in, ridx, rx_pat} = '0;
    tx_n = 0;
    wt(5);
    presetn <= 1'b1;
    t_avail();
    t_tm();
    t_stat();
    t_gate();
    t_pins();
    t_tx(1'b0, 8'hb2);
    t_tx(1'b1, 8'h4d);
    t_rx(1'b0, 8'h9c);
    t_rx(1'b1, 8'h63);
    summarize();
  end
endmodule // test_hsc_port
